// ### hdl/sad_consts.vh
// Address map constants for the system address decoder.
// Included by the decoder and its assertion checker; definitions only.
`ifndef SAD_CONSTS_VH
`define SAD_CONSTS_VH
`define SAD_PERIPH_BASE 32'h1000_0000
`define SAD_PERIPH_MASK 32'hFFF0_0000
`define SAD_SLOT_MASK 32'hFFFF_F000
`define SAD_OFF_MISC 32'h0001_2000
`define SAD_OFF_UART 32'h0001_3000
`define SAD_OFF_FLASH_SPI 32'h0001_4000
`define SAD_OFF_DMA 32'h0001_5000
`define SAD_OFF_QSPI1 32'h0002_4000
`define SAD_OFF_QSPI2 32'h0003_4000
`define SAD_IOCP_BASE 32'h5000_0000
`define SAD_IOCP_WIDTH 6'h1C
`define SAD_FLASH_BASE 32'h2000_0000
`define SAD_FLASH_WIDTH 6'h1D
`define SAD_IRAM_BASE 32'h0800_0000
`define SAD_DRAM_BASE 32'h0900_0000
`define SAD_RAM_WIDTH_SMALL 6'h0F
`define SAD_RAM_WIDTH_LARGE 6'h10
`define SAD_SYSMEM_BASE_SMALL 32'hA000_0000
`define SAD_SYSMEM_WIDTH_SMALL 6'h12
`define SAD_SYSMEM_BASE_LARGE 32'h8000_0000
`define SAD_SYSMEM_WIDTH_LARGE 6'h1F
`define SAD_SEL_W 13
`define SAD_SEL_IRAM 0
`define SAD_SEL_DRAM 1
`define SAD_SEL_FLASH 2
`define SAD_SEL_SYSMEM 3
`define SAD_SEL_IOCP 4
`define SAD_SEL_MISC 5
`define SAD_SEL_UART 6
`define SAD_SEL_FLASH_SPI 7
`define SAD_SEL_DMA 8
`define SAD_SEL_QSPI1 9
`define SAD_SEL_QSPI2 10
`define SAD_SEL_ERR 11
`define SAD_SEL_FLASHW 12
`endif

// ### hdl/sad_region_match.v
// Power-of-two aligned region match on a 32-bit address.
// Purely combinational; base assumed aligned to its size.
`timescale 1ns/1ps
`default_nettype none
module sad_region_match
(
    // Address and region
    input wire [31:0] addr,
    input wire [31:0] base,
    input wire [5:0] width,
    input wire enable,
    // Result
    output wire hit
);
    wire [31:0] mask;
    assign mask = (width >= 6'd32) ? 32'h0000_0000 : (32'hFFFF_FFFF << width);
    assign hit = enable && ((addr & mask) == (base & mask));
endmodule // sad_region_match
`default_nettype wire

// ### hdl/sad_decoder.v
// System address decoder with boot vector selection.
// Assumes one request per cycle, answered the next cycle; single clock.
`timescale 1ns/1ps
`default_nettype none
`include "sad_consts.vh"
// Operation
// R1: Peripheral space base configurable, default 0x1000_0000, one megabyte total.
// R2: Misc controller 4K slot at peripheral offset 0x1_2000.
// R3: Misc slot exists only for 600 and 900 class cores.
// R4: Serial port 4K slot at peripheral offset 0x1_3000.
// R5: First quad SPI 4K slot at peripheral offset 0x1_4000.
// R6: Micro DMA 4K slot at peripheral offset 0x1_5000.
// R7: Second quad SPI 4K slot at peripheral offset 0x2_4000.
// R8: Third quad SPI 4K slot at peripheral offset 0x3_4000.
// R9: Coherent port window, configurable base and width, default 0x5000_0000 upward 256MB.
// R10: Flash window configurable, default 0x2000_0000 to 0x3FFF_FFFF.
// R11: Flash window is read-only, reachable by fetches and loads.
// R12: First quad SPI leaves reset in execute-in-place mode.
// R13: Instruction RAM configurable base, 32KB small or 64KB large classes.
// R14: Data RAM configurable base, 32KB small or 64KB large classes.
// R15: Instruction RAM is reached over the system bus.
// R16: Core local instruction memory config overrides instruction RAM base and size.
// R17: Core local data memory config overrides data RAM base and size.
// R18: Small classes map system memory at 0xA000_0000, 256K on-chip SRAM.
// R19: Large classes map system memory from 0x8000_0000, external DDR.
// R20: Board build ties reset vector to flash window base.
// R21: Simulation build boots from image start, overridable by boot argument.
// R22: Accesses hitting no region answer with a bus error.
module sad_decoder
#(
    parameter CORE_CLASS = 900,
    parameter BOARD_BUILD = 1,
    parameter [31:0] peripheral_base_param = `SAD_PERIPH_BASE,
    parameter [31:0] iocp_base_param = `SAD_IOCP_BASE,
    parameter [5:0] iocp_width_param = `SAD_IOCP_WIDTH,
    parameter [31:0] flash_window_base_param = `SAD_FLASH_BASE,
    parameter [5:0] flash_window_width_param = `SAD_FLASH_WIDTH,
    parameter [31:0] instr_ram_base_param = `SAD_IRAM_BASE,
    parameter [31:0] data_ram_base_param = `SAD_DRAM_BASE,
    parameter [31:0] sysmem_base_param = (CORE_CLASS >= 600) ?
        `SAD_SYSMEM_BASE_LARGE : `SAD_SYSMEM_BASE_SMALL,
    parameter [5:0] sysmem_width_param = (CORE_CLASS >= 600) ?
        `SAD_SYSMEM_WIDTH_LARGE : `SAD_SYSMEM_WIDTH_SMALL
)
(
    // Clock and reset
    input wire clk,
    input wire rst,
    input wire clk_en,
    // Core local memory configuration
    input wire core_has_local_instr_mem,
    input wire [31:0] core_local_instr_mem_base,
    input wire [5:0] core_local_instr_mem_width,
    input wire core_has_local_data_mem,
    input wire [31:0] core_local_data_mem_base,
    input wire [5:0] core_local_data_mem_width,
    // Simulation boot address
    input wire [31:0] image_start_addr,
    input wire boot_addr_override,
    input wire [31:0] boot_addr,
    // Core request
    input wire req_valid,
    input wire [31:0] req_addr,
    input wire req_write,
    input wire req_fetch,
    // Decoded request
    output reg [`SAD_SEL_W-1:0] sel_q,
    output reg [31:0] sel_addr_q,
    output reg sel_write_q,
    output reg err_q,
    // Boot and controller setup
    output reg [31:0] reset_vector_q,
    output reg flash_quad_spi_execute_in_place_q
);
    localparam LARGE = (CORE_CLASS >= 600) ? 1 : 0;
    localparam [5:0] RAM_W = LARGE ? `SAD_RAM_WIDTH_LARGE : `SAD_RAM_WIDTH_SMALL; // R13 R14

    wire [31:0] periph_off;
    wire periph_hit;
    wire [31:0] iram_base;
    wire [5:0] iram_width;
    wire [31:0] dram_base;
    wire [5:0] dram_width;
    wire [`SAD_SEL_W-1:0] hit;
    reg [`SAD_SEL_W-1:0] sel_d;

    assign iram_base = core_has_local_instr_mem ?
        core_local_instr_mem_base : instr_ram_base_param; // R16
    assign iram_width = core_has_local_instr_mem ? core_local_instr_mem_width : RAM_W; // R16
    assign dram_base = core_has_local_data_mem ?
        core_local_data_mem_base : data_ram_base_param; // R17
    assign dram_width = core_has_local_data_mem ? core_local_data_mem_width : RAM_W; // R17

    // Peripheral window and slot offset
    assign periph_hit = ((req_addr & `SAD_PERIPH_MASK) ==
        (peripheral_base_param & `SAD_PERIPH_MASK)); // R1
    assign periph_off = (req_addr & ~`SAD_PERIPH_MASK) & `SAD_SLOT_MASK;

    // Memory regions
    sad_region_match u_iram
    (
        .addr(req_addr),
        .base(iram_base),
        .width(iram_width),
        .enable(1'b1),
        .hit(hit[`SAD_SEL_IRAM])
    ); // R15
    sad_region_match u_dram
    (
        .addr(req_addr),
        .base(dram_base),
        .width(dram_width),
        .enable(1'b1),
        .hit(hit[`SAD_SEL_DRAM])
    );
    sad_region_match u_flash
    (
        .addr(req_addr),
        .base(flash_window_base_param),
        .width(flash_window_width_param),
        .enable(1'b1),
        .hit(hit[`SAD_SEL_FLASH])
    ); // R10
    sad_region_match u_sysmem
    (
        .addr(req_addr),
        .base(sysmem_base_param),
        .width(sysmem_width_param),
        .enable(1'b1),
        .hit(hit[`SAD_SEL_SYSMEM])
    ); // R18 R19
    sad_region_match u_iocp
    (
        .addr(req_addr),
        .base(iocp_base_param),
        .width(iocp_width_param),
        .enable(1'b1),
        .hit(hit[`SAD_SEL_IOCP])
    ); // R9

    // Peripheral slots
    assign hit[`SAD_SEL_MISC] = periph_hit && (LARGE != 0) &&
        (periph_off == `SAD_OFF_MISC); // R2 R3
    assign hit[`SAD_SEL_UART] = periph_hit && (periph_off == `SAD_OFF_UART); // R4
    assign hit[`SAD_SEL_FLASH_SPI] = periph_hit && (periph_off == `SAD_OFF_FLASH_SPI); // R5
    assign hit[`SAD_SEL_DMA] = periph_hit && (periph_off == `SAD_OFF_DMA); // R6
    assign hit[`SAD_SEL_QSPI1] = periph_hit && (periph_off == `SAD_OFF_QSPI1); // R7
    assign hit[`SAD_SEL_QSPI2] = periph_hit && (periph_off == `SAD_OFF_QSPI2); // R8
    assign hit[`SAD_SEL_ERR] = 1'b0;
    assign hit[`SAD_SEL_FLASHW] = 1'b0;

    // Priority select: local RAMs first, then peripherals, then large windows
    always @*
    begin
        sel_d = {`SAD_SEL_W{1'b0}};
        if (!req_valid)
        begin
            sel_d = {`SAD_SEL_W{1'b0}};
        end
        else if (hit[`SAD_SEL_IRAM])
        begin
            sel_d[`SAD_SEL_IRAM] = 1'b1;
        end
        else if (hit[`SAD_SEL_DRAM])
        begin
            sel_d[`SAD_SEL_DRAM] = 1'b1;
        end
        else if (hit[`SAD_SEL_QSPI2:`SAD_SEL_MISC] != 6'h00)
        begin
            sel_d[`SAD_SEL_QSPI2:`SAD_SEL_MISC] = hit[`SAD_SEL_QSPI2:`SAD_SEL_MISC];
        end
        else if (hit[`SAD_SEL_FLASH])
        begin
            if (req_write)
            begin
                sel_d[`SAD_SEL_FLASHW] = 1'b1; // R11
            end
            else
            begin
                sel_d[`SAD_SEL_FLASH] = 1'b1; // R11
            end
        end
        else if (hit[`SAD_SEL_IOCP])
        begin
            sel_d[`SAD_SEL_IOCP] = 1'b1;
        end
        else if (hit[`SAD_SEL_SYSMEM])
        begin
            sel_d[`SAD_SEL_SYSMEM] = 1'b1;
        end
        else
        begin
            sel_d[`SAD_SEL_ERR] = 1'b1; // R22
        end
    end

    // Registered select and error answer
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sel_q <= {`SAD_SEL_W{1'b0}};
            sel_addr_q <= 32'h0000_0000;
            sel_write_q <= 1'b0;
            err_q <= 1'b0;
        end
        else if (clk_en)
        begin
            sel_q <= sel_d;
            sel_addr_q <= req_addr;
            sel_write_q <= req_write;
            err_q <= sel_d[`SAD_SEL_ERR] | sel_d[`SAD_SEL_FLASHW]; // R22 R11
        end
    end

    // Boot vector and flash controller mode
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            // Board build shows the flash base already while reset is held
            reset_vector_q <= (BOARD_BUILD != 0) ? flash_window_base_param : 32'h0000_0000; // R20
            flash_quad_spi_execute_in_place_q <= 1'b1; // R12
        end
        else if (clk_en)
        begin
            flash_quad_spi_execute_in_place_q <= 1'b1; // R12
            if (BOARD_BUILD != 0)
            begin
                reset_vector_q <= flash_window_base_param; // R20
            end
            else if (boot_addr_override)
            begin
                reset_vector_q <= boot_addr; // R21
            end
            else
            begin
                reset_vector_q <= image_start_addr; // R21
            end
        end
    end
endmodule // sad_decoder
`default_nettype wire

// ### verif/sad_decoder_chk.sv
// Assertion checker for the system address decoder.
// Sees only decoder ports; default map; class and build come in as parameters.
`timescale 1ns/1ps
`default_nettype none
`include "sad_consts.vh"
module sad_decoder_chk
#(
    parameter CORE_CLASS = 900,
    parameter BOARD_BUILD = 1
)
(
    // Clock and request
    input wire clk,
    input wire rst,
    input wire clk_en,
    input wire req_valid,
    input wire [31:0] req_addr,
    input wire req_write,
    // Decoded outputs
    input wire [`SAD_SEL_W-1:0] sel_q,
    input wire err_q,
    input wire [31:0] reset_vector_q,
    input wire flash_quad_spi_execute_in_place_q
);
    localparam LARGE = (CORE_CLASS >= 600) ? 1 : 0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    wire tk = clk_en && req_valid;
    wire [19:0] pg = req_addr[31:12];
    wire [12:0] misc_sel = (LARGE != 0) ? 13'h0020 : 13'h0800;
    wire sysmem_pick = (LARGE != 0) ? req_addr[31] : (req_addr[31:18] == 14'h2800);
    a_misc_slot: assert property (tk && pg == 20'h10012 |=> sel_q == misc_sel)
        else $error("misc slot");
    a_uart_slot: assert property (tk && pg == 20'h10013 |=> sel_q == 13'h0040)
        else $error("uart slot");
    a_flash_spi_slot: assert property (tk && pg == 20'h10014 |=> sel_q == 13'h0080)
        else $error("flash spi slot");
    a_dma_slot: assert property (tk && pg == 20'h10015 |=> sel_q == 13'h0100)
        else $error("dma slot");
    a_qspi1_slot: assert property (tk && pg == 20'h10024 |=> sel_q == 13'h0200)
        else $error("qspi1 slot");
    a_qspi2_slot: assert property (tk && pg == 20'h10034 |=> sel_q == 13'h0400)
        else $error("qspi2 slot");
    a_periph_hole: assert property (tk && pg == 20'h10016 |=> sel_q[11] && err_q)
        else $error("peripheral hole");
    a_iocp_win: assert property (tk && req_addr[31:28] == 4'h5 |=> sel_q == 13'h0010)
        else $error("coherent window");
    a_flash_read: assert property (tk && req_addr[31:29] == 3'h1 && !req_write
        |=> sel_q == 13'h0004 && !err_q)
        else $error("flash read");
    a_flash_write: assert property (tk && req_addr[31:29] == 3'h1 && req_write
        |=> sel_q == 13'h1000 && err_q)
        else $error("flash write");
    a_sysmem_hit: assert property (tk && sysmem_pick |=> sel_q == 13'h0008)
        else $error("system memory");
    a_idle_quiet: assert property (clk_en && !req_valid |=> sel_q == 13'h0000 && !err_q)
        else $error("idle select");
    a_boot_vec: assert property (clk_en && BOARD_BUILD != 0 |=> reset_vector_q == 32'h2000_0000)
        else $error("boot vector");
    a_exec_mode: assert property (flash_quad_spi_execute_in_place_q)
        else $error("execute in place mode");
    c_error: cover property (tk ##1 err_q);
    c_burst: cover property (tk [*3]);
    c_write: cover property (tk && req_write);
endmodule // sad_decoder_chk
`default_nettype wire

// ### verif/sad_slave_model.sv
// Slave side model counting accesses handed to any target.
// Assumes one-hot select, clock enable held high.
`timescale 1ns/1ps
`default_nettype none
module sad_slave_model
(
    // Clock and select
    input wire clk,
    input wire rst,
    input wire [12:0] sel_q,
    // Accepted access count
    output logic [15:0] hits_q
);
    always @(posedge clk or posedge rst)
    begin
        if (rst)
            hits_q <= 16'h0000;
        else if (|sel_q)
            hits_q <= hits_q + 16'h0001;
    end
endmodule // sad_slave_model
`default_nettype wire

// ### verif/soc_address_decoder_bench.sv
// Self-checking bench for the system address decoder.
// Drives at the falling edge; large core class board build and small core class simulation build.
`timescale 1ns/1ps
`default_nettype none
module soc_address_decoder_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic has_i = 1'b0;
    logic has_d = 1'b0;
    logic [31:0] img = 32'h0800_0100;
    logic ovr = 1'b0;
    logic [31:0] baddr = 32'h0000_0000;
    logic vld = 1'b0;
    logic [31:0] adr = 32'h0000_0000;
    logic wr = 1'b0;
    logic [12:0] sel_q, sel_s;
    logic err_q, err_s, exec_mode;
    logic [31:0] rv, rv_s;
    logic [15:0] hits;
    logic [13:0] exp_q[$];
    logic [13:0] exp_s_q[$];
    int num_errors = 0;
    int n_tests = 0;
    int seed = 32'h6FC6CD8E;
    int nreq = 0;
    sad_decoder u_dut (.clk(clk), .rst(rst), .clk_en(1'b1),
        .core_has_local_instr_mem(has_i), .core_local_instr_mem_base(32'h6000_0000),
        .core_local_instr_mem_width(6'h10), .core_has_local_data_mem(has_d),
        .core_local_data_mem_base(32'h7000_0000), .core_local_data_mem_width(6'h10),
        .image_start_addr(img), .boot_addr_override(ovr), .boot_addr(baddr),
        .req_valid(vld), .req_addr(adr), .req_write(wr), .req_fetch(adr[2]),
        .sel_q(sel_q), .sel_addr_q(), .sel_write_q(), .err_q(err_q),
        .reset_vector_q(rv), .flash_quad_spi_execute_in_place_q(exec_mode));
    // Small class, simulation build, same request stream
    sad_decoder #(.CORE_CLASS(300), .BOARD_BUILD(0)) u_sim (.clk(clk), .rst(rst), .clk_en(1'b1),
        .core_has_local_instr_mem(has_i), .core_local_instr_mem_base(32'h6000_0000),
        .core_local_instr_mem_width(6'h10), .core_has_local_data_mem(has_d),
        .core_local_data_mem_base(32'h7000_0000), .core_local_data_mem_width(6'h10),
        .image_start_addr(img), .boot_addr_override(ovr), .boot_addr(baddr),
        .req_valid(vld), .req_addr(adr), .req_write(wr), .req_fetch(adr[2]),
        .sel_q(sel_s), .sel_addr_q(), .sel_write_q(), .err_q(err_s),
        .reset_vector_q(rv_s), .flash_quad_spi_execute_in_place_q());
    sad_slave_model u_slv (.clk(clk), .rst(rst), .sel_q(sel_q), .hits_q(hits));
    initial forever #2 clk = ~clk;
    task automatic check(input string what, input logic [31:0] ex, input logic [31:0] got);
        n_tests++;
        if (got !== ex)
        begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", what, ex, got);
        end
    endtask
    task automatic req(input logic [31:0] a, input logic w, input logic [13:0] ex,
        input logic [13:0] exs);
        @(negedge clk);
        vld <= 1'b1;
        adr <= a;
        wr <= w;
        exp_q.push_back(ex);
        exp_s_q.push_back(exs);
        nreq++;
    endtask
    task automatic close_out();
        $display("Checks %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(negedge clk)
    begin
        if (!rst && sel_q !== 13'h0000)
            check("select", {18'h0, exp_q.pop_front()}, {18'h0, err_q, sel_q});
        if (!rst && sel_s !== 13'h0000)
            check("small select", {18'h0, exp_s_q.pop_front()}, {18'h0, err_s, sel_s});
    end
    initial
    begin
        repeat (20) @(posedge clk);
        check("vector in reset", 32'h2000_0000, rv);
        check("small vector in reset", 32'h0, rv_s);
        @(negedge clk);
        rst <= 1'b0;
        repeat (2) @(negedge clk);
        check("vector", 32'h2000_0000, rv);
        check("image start vector", img, rv_s);
        check("execute in place", 32'h1, {31'h0, exec_mode});
        req(32'h1001_2004, 0, 14'h0020, 14'h2800);
        req(32'h1001_3000, 0, 14'h0040, 14'h0040);
        req(32'h1001_4FFC, 0, 14'h0080, 14'h0080);
        req(32'h1001_5000, 1, 14'h0100, 14'h0100);
        req(32'h1002_4000, 0, 14'h0200, 14'h0200);
        req(32'h1003_4FFF, 0, 14'h0400, 14'h0400);
        req(32'h1001_6000, 0, 14'h2800, 14'h2800);
        req(32'h100F_F000, 0, 14'h2800, 14'h2800);
        req(32'h1010_0000, 0, 14'h2800, 14'h2800);
        $display("Test peripheral slots done");
        req(32'h0800_FFFC, 0, 14'h0001, 14'h2800);
        req(32'h0801_0000, 0, 14'h2800, 14'h2800);
        req(32'h0900_FFFC, 1, 14'h0002, 14'h2800);
        req(32'h2000_0000, 0, 14'h0004, 14'h0004);
        req(32'h3FFF_FFFC, 0, 14'h0004, 14'h0004);
        req(32'h2000_0100, 1, 14'h3000, 14'h3000);
        req(32'h8000_0000, 1, 14'h0008, 14'h2800);
        req(32'hFFFF_FFFC, 0, 14'h0008, 14'h2800);
        req(32'hA003_FFFC, 0, 14'h0008, 14'h0008);
        req(32'hA004_0000, 0, 14'h0008, 14'h2800);
        req(32'h5FFF_FFFC, 0, 14'h0010, 14'h0010);
        req(32'h6000_0000, 0, 14'h2800, 14'h2800);
        repeat (8)
            req(32'h0800_0000 | ($random(seed) & 32'h0000_7FFC), $random(seed), 14'h0001, 14'h0001);
        $display("Test memory regions done");
        @(negedge clk);
        vld <= 1'b0;
        has_i <= 1'b1;
        has_d <= 1'b1;
        img <= $random(seed);
        baddr <= $random(seed);
        ovr <= 1'b1;
        @(negedge clk);
        check("boot override vector", baddr, rv_s);
        req(32'h6000_1000, 0, 14'h0001, 14'h0001);
        req(32'h7000_FFFC, 0, 14'h0002, 14'h0002);
        req(32'h0800_0000, 0, 14'h2800, 14'h2800);
        req(32'h0900_0000, 0, 14'h2800, 14'h2800);
        @(negedge clk);
        vld <= 1'b0;
        ovr <= 1'b0;
        repeat (3) @(negedge clk);
        check("vector kept", 32'h2000_0000, rv);
        check("image vector", img, rv_s);
        check("slave hits", nreq, {16'h0, hits});
        check("pending", 32'h0, exp_q.size() + exp_s_q.size());
        $display("Test local memory override done");
        close_out();
    end
    initial
    begin
        #20000;
        num_errors++;
        close_out();
    end
endmodule // soc_address_decoder_bench
bind sad_decoder sad_decoder_chk #(.CORE_CLASS(CORE_CLASS), .BOARD_BUILD(BOARD_BUILD))
    u_chk (.clk(clk), .rst(rst), .clk_en(clk_en),
    .req_valid(req_valid), .req_addr(req_addr), .req_write(req_write), .sel_q(sel_q),
    .err_q(err_q), .reset_vector_q(reset_vector_q),
    .flash_quad_spi_execute_in_place_q(flash_quad_spi_execute_in_place_q));
`default_nettype wire
